// *** verilog/xtm_pkg.sv ***
// Shared constants, types and helpers for the transmit MAC
package xtm_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 64;
  localparam int LANES = 8;
  localparam int MTY_W = 3;
  localparam int DDR_W = 32;
  localparam int DDR_LANES = 4;
  localparam int COL_W = DATA_W + LANES;
  localparam int CNT_W = 4;
  localparam int FCS_BYTES = 4;
  localparam int CDC_ADDR_W = 2;
  localparam int IPG_COLS_DEF = 2;

  // ----------------------------------------------------------------
  // Link control octets and frame constants
  // ----------------------------------------------------------------
  localparam logic [7:0] XC_IDLE = 8'h07;
  localparam logic [7:0] XC_START = 8'hfb;
  localparam logic [7:0] XC_TERM = 8'hfd;
  localparam logic [7:0] XC_ERR = 8'hfe;
  localparam logic [7:0] XC_PRE = 8'h55;
  localparam logic [7:0] XC_SFD = 8'hd5;
  localparam logic [LANES-1:0] CTL_NONE = 8'h00;
  localparam logic [LANES-1:0] CTL_ALL = 8'hff;
  localparam logic [LANES-1:0] CTL_START = 8'h01;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [CNT_W-1:0] FULL_WORD = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DATA,
    ST_TAIL,
    ST_ABORT,
    ST_DROP,
    ST_IPG
  } xtm_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Reflected CRC-32 over one octet, bit 0 first on the wire
  function automatic logic [31:0] xtm_crc_byte(input logic [31:0] crc,
                                               input logic [7:0] b);
    logic [31:0] c;
    c = crc ^ {24'h000000, b};
    for (int k = 0; k < 8; k++)
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    return c;
  endfunction : xtm_crc_byte

  // Client byte 0 sits in bits 63:56; link lane 0 goes out first
  function automatic logic [DATA_W-1:0] xtm_swap(input logic [DATA_W-1:0] w);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < LANES; i++)
      r[8*i +: 8] = w[DATA_W-1-8*i -: 8];
    return r;
  endfunction : xtm_swap

endpackage : xtm_pkg

// *** verilog/xtm_col_cdc.sv ***
// Gray-pointer crossing for link columns between MAC and link clocks
`timescale 1ns/1ps
module xtm_col_cdc #(
  parameter int WIDTH = 72,
  parameter int ADDR_W = 2
) (
  input wire logic wr_clk_i,
  input wire logic wr_nrst_i,
  input wire logic wr_valid_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  output logic wr_ready_o,
  input wire logic rd_clk_i,
  input wire logic rd_nrst_i,
  input wire logic rd_ready_i,
  output logic rd_valid_o,
  output logic [WIDTH-1:0] rd_data_o
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [ADDR_W:0] ONE = {{ADDR_W{1'b0}}, 1'b1};

  function automatic logic [ADDR_W:0] to_gray(input logic [ADDR_W:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [ADDR_W:0] wbin_q, wgray_q, rbin_q, rgray_q;
  logic [ADDR_W:0] rg_s1_q, rg_s2_q, wg_s1_q, wg_s2_q;

  wire logic full = wgray_q == {~rg_s2_q[ADDR_W:ADDR_W-1],
                                rg_s2_q[ADDR_W-2:0]};
  wire logic empty = rgray_q == wg_s2_q;
  wire logic do_wr = wr_valid_i && !full;
  wire logic do_rd = rd_ready_i && !empty;
  wire logic [ADDR_W:0] wbin_nx = wbin_q + ONE;
  wire logic [ADDR_W:0] rbin_nx = rbin_q + ONE;

  assign wr_ready_o = !full;
  assign rd_valid_o = !empty;
  assign rd_data_o = mem_q[rbin_q[ADDR_W-1:0]];

  // Storage has no reset; only pointers need a defined value
  always_ff @(posedge wr_clk_i)
    if (do_wr)
      mem_q[wbin_q[ADDR_W-1:0]] <= wr_data_i;

  always_ff @(posedge wr_clk_i or negedge wr_nrst_i)
    if (!wr_nrst_i)
    begin
      wbin_q <= '0;
      wgray_q <= '0;
      rg_s1_q <= '0;
      rg_s2_q <= '0;
    end
    else
    begin
      rg_s1_q <= rgray_q;
      rg_s2_q <= rg_s1_q;
      if (do_wr)
      begin
        wbin_q <= wbin_nx;
        wgray_q <= to_gray(wbin_nx);
      end
    end

  always_ff @(posedge rd_clk_i or negedge rd_nrst_i)
    if (!rd_nrst_i)
    begin
      rbin_q <= '0;
      rgray_q <= '0;
      wg_s1_q <= '0;
      wg_s2_q <= '0;
    end
    else
    begin
      wg_s1_q <= wgray_q;
      wg_s2_q <= wg_s1_q;
      if (do_rd)
      begin
        rbin_q <= rbin_nx;
        rgray_q <= to_gray(rbin_nx);
      end
    end

endmodule : xtm_col_cdc

// *** verilog/xtm_tx_mac.sv ***
// Transmit MAC: client word intake, framing, CRC and link output
`timescale 1ns/1ps

// Summary of operation
// R1: Read client words, add preamble, FCS and terminate, send on link.
// R2: Source keeps valid words gapless between first and last word.
// R3: One further valid word after read drops is still accepted.
// R4: Source presents one 64-bit data word per transfer.
// R5: Valid high only when data and side inputs are meaningful.
// R6: Frame-first marker is high one cycle on the first word.
// R7: Frame-last marker is high one cycle on the last word.
// R8: Empty count on last word gives unused lanes; locates final byte.
// R9: Count N leaves N least significant lanes unused; zero means full.
// R10: Data-available only when the whole frame can be delivered.
// R11: Data-available comes from the FIFO, or from client logic.
// R12: Error marker is raised together with the frame-last marker.
// R13: Read is low while FCS or gap columns are being inserted.
// R14: Source stops presenting data one cycle after read drops.
// R15: Source may present data the cycle after read rises.
// R16: Without a FIFO, client logic mimics the FIFO signalling.
// R17: Single-rate link for internal PHY, double-rate for external PHY.
// R18: Double-rate link has 32 data bits, 4 control bits, a clock.
// R19: Double-rate data and control change on both link clock edges.
// R20: Forwarded link clock lags data and control by 90 degrees.
// R21: Control bit set exactly when its lane carries a control octet.
// R22: On underflow end frame with error octets, drop words until next first.
// R23: Single-rate link has 64 data bits and 8 control bits.
module xtm_tx_mac #(
  parameter int IPG_COLS = xtm_pkg::IPG_COLS_DEF,
  parameter bit DDR_MODE = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic link_clk_i,
  input wire logic link_clk90_i,
  input wire logic [xtm_pkg::DATA_W-1:0] client_dat_i,
  input wire logic client_valid_i,
  input wire logic client_frame_first_i,
  input wire logic client_frame_last_i,
  input wire logic [xtm_pkg::MTY_W-1:0] client_empty_i,
  input wire logic client_dav_i,
  input wire logic client_err_i,
  output logic client_read_o,
  output logic [xtm_pkg::DATA_W-1:0] sdr_data_o,
  output logic [xtm_pkg::LANES-1:0] sdr_ctrl_o,
  output logic [xtm_pkg::DDR_W-1:0] ddr_data_o,
  output logic [xtm_pkg::DDR_LANES-1:0] ddr_ctrl_o,
  output logic ddr_clk_o
);
  import xtm_pkg::*;

  // ----------------------------------------------------------------
  // Word holding register and state
  // ----------------------------------------------------------------
  xtm_state_t state_q, state_d;
  logic [DATA_W-1:0] w_dat_q;
  logic w_first_q, w_last_q, w_err_q, w_v_q, read_q;
  logic [MTY_W-1:0] w_mty_q;
  logic [31:0] crc_q;
  logic [COL_W-1:0] tail_q;
  logic [7:0] ipg_q;
  logic col_rdy;

  localparam logic [7:0] IPG_LAST = 8'(IPG_COLS - 1);
  localparam logic [DATA_W-1:0] IDLE_DAT = {LANES{XC_IDLE}};
  localparam logic [DATA_W-1:0] PRE_DAT = {XC_SFD, {6{XC_PRE}}, XC_START};
  localparam logic [DATA_W-1:0] ABORT_DAT = {XC_TERM, {7{XC_ERR}}};

  // Only one word may be in flight, so read waits for an empty holder
  // and for the previous request to land; one word per three cycles at most in ST_DATA, one per two in ST_DROP, no overrun.
  wire logic want_data = state_q == ST_DATA || state_q == ST_DROP;
  assign client_read_o = want_data && !w_v_q && !read_q; // R3 R13

  wire logic capture = client_valid_i
                       && (state_q != ST_DROP || client_frame_first_i); // R22
  wire logic ufl = state_q == ST_DATA && read_q && !client_valid_i; // R22
  wire logic start = state_q == ST_IDLE && col_rdy
                     && (client_dav_i || w_v_q); // R10
  wire logic take = state_q == ST_DATA && w_v_q && col_rdy;
  wire logic drop_end = state_q == ST_DROP && client_valid_i
                        && (client_frame_first_i || client_frame_last_i);

  // ----------------------------------------------------------------
  // CRC and end-of-frame tail
  // ----------------------------------------------------------------
  wire logic [CNT_W-1:0] n_bytes = w_last_q
                                   ? FULL_WORD - CNT_W'(w_mty_q)
                                   : FULL_WORD; // R8 R9
  wire logic [DATA_W-1:0] w_lanes = xtm_swap(w_dat_q);
  logic [31:0] crc_nx;
  logic [2*COL_W-1:0] tail_all;
  logic [31:0] fcs;
  logic [CNT_W:0] term_pos;

  always_comb
  begin
    crc_nx = crc_q;
    for (int i = 0; i < LANES; i++)
      if (CNT_W'(i) < n_bytes)
        crc_nx = xtm_crc_byte(crc_nx, w_lanes[8*i +: 8]);
  end

  assign fcs = ~crc_nx;
  assign term_pos = {1'b0, n_bytes} + (CNT_W+1)'(FCS_BYTES)
                    + (CNT_W+1)'(w_err_q);

  // Two columns: lanes of data, FCS low byte first, error, terminate
  always_comb
  begin
    logic [7:0] b;
    logic c;
    logic [CNT_W:0] p;
    b = XC_IDLE;
    c = 1'b1;
    p = '0;
    tail_all = '0;
    for (int i = 0; i < 2*LANES; i++)
    begin
      p = (CNT_W+1)'(i);
      if (p < {1'b0, n_bytes})
      begin
        b = w_lanes[8*(i%LANES) +: 8];
        c = 1'b0;
      end
      else if (p < {1'b0, n_bytes} + (CNT_W+1)'(FCS_BYTES))
      begin
        b = 8'(fcs >> (8*(p - {1'b0, n_bytes})));
        c = 1'b0;
      end
      else if (p == term_pos)
      begin
        b = XC_TERM;
        c = 1'b1;
      end
      else if (p < term_pos)
      begin
        b = XC_ERR; // R12
        c = 1'b1;
      end
      else
      begin
        b = XC_IDLE;
        c = 1'b1;
      end
      tail_all[(i/LANES)*COL_W + 8*(i%LANES) +: 8] = b;
      tail_all[(i/LANES)*COL_W + DATA_W + (i%LANES)] = c; // R21
    end
  end

  wire logic need_tail = term_pos >= (CNT_W+1)'(LANES);

  // ----------------------------------------------------------------
  // Column selection toward the crossing
  // ----------------------------------------------------------------
  wire logic st_tail = state_q == ST_TAIL;
  wire logic st_abort = state_q == ST_ABORT;
  wire logic st_ipg = state_q == ST_IPG;
  wire logic col_wr = start || take
                      || (col_rdy && (st_tail || st_abort || st_ipg));
  wire logic [DATA_W-1:0] col_dat =
    start ? PRE_DAT :
    (take && w_last_q) ? tail_all[DATA_W-1:0] :
    take ? w_lanes :
    st_tail ? tail_q[DATA_W-1:0] :
    st_abort ? ABORT_DAT : IDLE_DAT; // R1
  wire logic [LANES-1:0] col_ctl =
    start ? CTL_START :
    (take && w_last_q) ? tail_all[COL_W-1:DATA_W] :
    take ? CTL_NONE :
    st_tail ? tail_q[COL_W-1:DATA_W] : CTL_ALL; // R21

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
        if (start)
          state_d = ST_DATA;
      ST_DATA:
        if (ufl)
          state_d = ST_ABORT; // R22
        else if (take && w_last_q)
          state_d = need_tail ? ST_TAIL : ST_IPG; // R13
      ST_TAIL:
        if (col_rdy)
          state_d = ST_IPG;
      ST_ABORT:
        if (col_rdy)
          state_d = ST_DROP;
      ST_DROP:
        if (drop_end)
          state_d = ST_IPG; // R22
      ST_IPG:
        if (col_rdy && ipg_q == IPG_LAST)
          state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      state_q <= ST_IDLE;
      read_q <= 1'b0;
      w_v_q <= 1'b0;
      w_dat_q <= '0;
      w_first_q <= 1'b0;
      w_last_q <= 1'b0;
      w_err_q <= 1'b0;
      w_mty_q <= '0;
      crc_q <= CRC_INIT;
      tail_q <= '0;
      ipg_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      read_q <= client_read_o;
      if (capture)
      begin
        w_v_q <= 1'b1; // R3
        w_dat_q <= client_dat_i;
        w_first_q <= client_frame_first_i;
        w_last_q <= client_frame_last_i;
        w_err_q <= client_err_i;
        w_mty_q <= client_empty_i;
      end
      else if (take)
        w_v_q <= 1'b0;
      if (start)
        crc_q <= CRC_INIT;
      else if (take)
        crc_q <= crc_nx;
      if (take)
        tail_q <= tail_all[2*COL_W-1:COL_W];
      if (!st_ipg)
        ipg_q <= '0;
      else if (col_rdy)
        ipg_q <= ipg_q + 8'h01;
    end

  // ----------------------------------------------------------------
  // Clock crossing and link side
  // ----------------------------------------------------------------
  logic lrst_s1_q, lrst_q;
  logic l_vld;
  logic [COL_W-1:0] l_col;
  logic [DATA_W-1:0] lc_dat_q;
  logic [LANES-1:0] lc_ctl_q;
  logic [DDR_W-1:0] hi_dat_q;
  logic [DDR_LANES-1:0] hi_ctl_q;

  always_ff @(posedge link_clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      lrst_s1_q <= 1'b0;
      lrst_q <= 1'b0;
    end
    else
    begin
      lrst_s1_q <= 1'b1;
      lrst_q <= lrst_s1_q;
    end

  // Full crossing stalls column writes, which in turn holds read low
  xtm_col_cdc #(
    .WIDTH (COL_W),
    .ADDR_W (CDC_ADDR_W)
  ) u_cdc (
    .wr_clk_i (ref_clk_i),
    .wr_nrst_i (nrst_i),
    .wr_valid_i (col_wr),
    .wr_data_i ({col_ctl, col_dat}),
    .wr_ready_o (col_rdy),
    .rd_clk_i (link_clk_i),
    .rd_nrst_i (lrst_q),
    .rd_ready_i (1'b1),
    .rd_valid_o (l_vld),
    .rd_data_o (l_col)
  );

  // Link never stalls: an empty crossing yields an idle column
  always_ff @(posedge link_clk_i or negedge lrst_q)
    if (!lrst_q)
    begin
      lc_dat_q <= IDLE_DAT;
      lc_ctl_q <= CTL_ALL;
    end
    else
    begin
      lc_dat_q <= l_vld ? l_col[DATA_W-1:0] : IDLE_DAT;
      lc_ctl_q <= l_vld ? l_col[COL_W-1:DATA_W] : CTL_ALL;
    end

  // Upper four lanes follow on the falling edge
  always_ff @(negedge link_clk_i or negedge lrst_q)
    if (!lrst_q)
    begin
      hi_dat_q <= IDLE_DAT[DDR_W-1:0];
      hi_ctl_q <= CTL_ALL[DDR_LANES-1:0];
    end
    else
    begin
      hi_dat_q <= lc_dat_q[DATA_W-1:DDR_W]; // R19
      hi_ctl_q <= lc_ctl_q[LANES-1:DDR_LANES];
    end

  assign sdr_data_o = DDR_MODE ? IDLE_DAT : lc_dat_q; // R17 R23
  assign sdr_ctrl_o = DDR_MODE ? CTL_ALL : lc_ctl_q;
  assign ddr_data_o = !DDR_MODE ? IDLE_DAT[DDR_W-1:0] :
                      link_clk_i ? lc_dat_q[DDR_W-1:0] : hi_dat_q; // R18 R19
  assign ddr_ctrl_o = !DDR_MODE ? CTL_ALL[DDR_LANES-1:0] :
                      link_clk_i ? lc_ctl_q[DDR_LANES-1:0] : hi_ctl_q;
  // Lagging clock comes from the same PLL as the link clock
  assign ddr_clk_o = link_clk90_i; // R20

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_READ_LOW_INSERT: assert property (@(posedge ref_clk_i) // R13
    disable iff (!nrst_i)
    (st_tail || st_ipg || st_abort) |-> !client_read_o)
    else $error("read high while inserting FCS or gap");

  AST_ONE_MORE_WORD: assert property (@(posedge ref_clk_i) // R3
    disable iff (!nrst_i)
    (client_read_o ##1 (client_valid_i && !client_read_o))
      |=> (w_v_q || ($past(state_q) == ST_DROP
      && !$past(client_frame_first_i))))
    else $error("word after read drop was lost");

  AST_UFL_ABORT: assert property (@(posedge ref_clk_i) // R22
    disable iff (!nrst_i)
    ufl |=> st_abort ##[0:20] (state_q == ST_DROP))
    else $error("underflow did not abort the frame");

  AST_ABORT_COL: assert property (@(posedge ref_clk_i) // R22
    disable iff (!nrst_i)
    (st_abort && col_wr) |-> (col_ctl == CTL_ALL
      && col_dat[7:0] == XC_ERR && col_dat[63:56] == XC_TERM))
    else $error("abort column is malformed");

  AST_PREAMBLE: assert property (@(posedge ref_clk_i) // R1
    disable iff (!nrst_i)
    start |-> (col_ctl == CTL_START && col_dat[7:0] == XC_START)
      ##1 (state_q == ST_DATA))
    else $error("frame did not open with start column");

  AST_DATA_CTRL: assert property (@(posedge ref_clk_i) // R21
    disable iff (!nrst_i)
    (take && !w_last_q) |-> col_ctl == CTL_NONE)
    else $error("control bit set on a data lane");

  AST_FULL_LAST: assert property (@(posedge ref_clk_i) // R8 R9
    disable iff (!nrst_i)
    (take && w_last_q && w_mty_q == 3'h0 && !w_err_q)
      |-> col_ctl == CTL_NONE ##1 (st_tail && tail_q[DATA_W+4]
      && tail_q[39:32] == XC_TERM && !tail_q[DATA_W+3]))
    else $error("full last word not followed by FCS then terminate");

  AST_SHORT_LAST: assert property (@(posedge ref_clk_i) // R8 R9
    disable iff (!nrst_i)
    (take && w_last_q && w_mty_q == 3'h7 && !w_err_q)
      |-> (col_ctl == 8'he0 && col_dat[47:40] == XC_TERM)
      ##1 st_ipg)
    else $error("one-byte last word framed wrongly");

  AST_DDR_HIGH: assert property (@(posedge link_clk_i) // R19
    disable iff (!lrst_q)
    hi_dat_q == lc_dat_q[DATA_W-1:DDR_W])
    else $error("falling edge half does not follow column");

  AST_IPG_LEN: assert property (@(posedge ref_clk_i) // R13
    disable iff (!nrst_i)
    (st_ipg && col_rdy && ipg_q == IPG_LAST) |=> state_q == ST_IDLE)
    else $error("gap length differs from setting");

endmodule : xtm_tx_mac

// *** bench/xtm_src_model.sv ***
// Client source model that answers the MAC read strobe
`timescale 1ns/1ps
module xtm_src_model (
  input wire logic clk_i,
  input wire logic read_i,
  input wire logic go_i,
  input wire logic [7:0] len_i,
  input wire logic [xtm_pkg::MTY_W-1:0] empty_i,
  input wire logic err_i,
  input wire logic [7:0] gap_i,
  input wire logic [7:0] base_i,
  output logic [xtm_pkg::DATA_W-1:0] dat_o,
  output logic valid_o,
  output logic first_o,
  output logic last_o,
  output logic [xtm_pkg::MTY_W-1:0] empty_o,
  output logic dav_o,
  output logic err_o,
  output int reads_o
);
  import xtm_pkg::*;
  int idx;
  logic busy;
  logic skipped;
  logic rd;
  logic go;
  initial
  begin
    {valid_o, first_o, last_o, dav_o, err_o, busy, skipped} = '0;
    dat_o = '0;
    empty_o = '0;
    idx = 0;
    reads_o = 0;
  end
  // Acts one step after the edge, like the real source
  always @(posedge clk_i)
  begin
    rd = read_i;
    go = go_i;
    #1;
    if (rd)
      reads_o++;
    if (go)
    begin
      dav_o = 1'b1;
      busy = 1'b1;
      skipped = 1'b0;
      idx = 0;
      reads_o = 0;
    end
    else if (rd && busy && !(idx == gap_i && !skipped))
    begin
      dav_o = 1'b0;
      valid_o = 1'b1;
      for (int j = 0; j < 8; j++)
        dat_o[63-8*j -: 8] = base_i + 8'(8*idx+j);
      first_o = (idx == 0);
      last_o = (idx == len_i - 1);
      err_o = last_o & err_i;
      empty_o = last_o ? empty_i : '0;
      idx++;
      busy = (idx < len_i);
    end
    else
    begin
      if (rd && busy)
        skipped = 1'b1;
      {valid_o, first_o, last_o, err_o} = '0;
      // Released bus shows the inverse so stale data never matches
      dat_o = ~dat_o;
      empty_o = ~empty_o;
    end
  end
endmodule : xtm_src_model

// *** bench/xtm_tx_mac_bench.sv ***
// Self-checking bench for the transmit MAC
`timescale 1ns/1ps
module xtm_tx_mac_bench;
  import xtm_pkg::*;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic link90;
  logic nrst = 1'b0;
  logic go = 1'b0;
  logic [7:0] m_len = 8'h01;
  logic [2:0] m_emp = 3'h0;
  logic m_err = 1'b0;
  logic [7:0] m_gap = 8'hff;
  logic [7:0] m_base = 8'h00;
  logic [DATA_W-1:0] dat;
  logic valid, first, last, dav, err, rd, ddr_clk;
  logic [2:0] emp;
  logic [DATA_W-1:0] sdr_data;
  logic [LANES-1:0] sdr_ctrl;
  logic [DDR_W-1:0] ddr_data;
  logic [DDR_LANES-1:0] ddr_ctrl;
  int m_reads;
  int failures = 0;
  int cmp_count = 0;
  int term_cnt = 0;
  logic [8:0] lnk_q[$];
  logic [DATA_W-1:0] s_data;
  logic [LANES-1:0] s_ctrl;
  logic [DDR_LANES-1:0] s_dctrl;
  logic [8:0] sdr_q[$];

  // ----------------------------------------------------------------
  // Clocks, design and partner
  // ----------------------------------------------------------------
  always #5 ref_clk = ~ref_clk;
  initial
  begin
    #3;
    forever #16 link_clk = ~link_clk;
  end
  assign #8 link90 = link_clk;

  xtm_tx_mac u_dut (.ref_clk_i(ref_clk), .nrst_i(nrst),
    .link_clk_i(link_clk), .link_clk90_i(link90), .client_dat_i(dat),
    .client_valid_i(valid), .client_frame_first_i(first),
    .client_frame_last_i(last), .client_empty_i(emp),
    .client_dav_i(dav), .client_err_i(err), .client_read_o(rd),
    .sdr_data_o(sdr_data), .sdr_ctrl_o(sdr_ctrl), .ddr_data_o(ddr_data),
    .ddr_ctrl_o(ddr_ctrl), .ddr_clk_o(ddr_clk));

  // Single-rate copy on the same stimulus; it reads in lockstep
  xtm_tx_mac #(.DDR_MODE(1'b0)) u_dut_sdr (.ref_clk_i(ref_clk),
    .nrst_i(nrst), .link_clk_i(link_clk), .link_clk90_i(link90),
    .client_dat_i(dat), .client_valid_i(valid),
    .client_frame_first_i(first), .client_frame_last_i(last),
    .client_empty_i(emp), .client_dav_i(dav), .client_err_i(err),
    .client_read_o(), .sdr_data_o(s_data), .sdr_ctrl_o(s_ctrl),
    .ddr_data_o(), .ddr_ctrl_o(s_dctrl), .ddr_clk_o());

  xtm_src_model u_src (.clk_i(ref_clk), .read_i(rd), .go_i(go),
    .len_i(m_len), .empty_i(m_emp), .err_i(m_err), .gap_i(m_gap),
    .base_i(m_base), .dat_o(dat), .valid_o(valid), .first_o(first),
    .last_o(last), .empty_o(emp), .dav_o(dav), .err_o(err),
    .reads_o(m_reads));

  // Lanes 0-3 in the high half, 4-7 in the low half, in wire order
  always @(link_clk)
  begin
    #4;
    for (int i = 0; i < 4; i++)
    begin
      lnk_q.push_back({ddr_ctrl[i], ddr_data[8*i +: 8]});
      if (ddr_ctrl[i] === 1'b1 && ddr_data[8*i +: 8] === XC_TERM)
        term_cnt++;
    end
  end

  // Single-rate lanes stand for a whole link cycle, all eight at once
  always @(posedge link_clk)
  begin
    #4;
    for (int i = 0; i < 8; i++)
      sdr_q.push_back({s_ctrl[i], s_data[8*i +: 8]});
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] crc_upd(input logic [31:0] c,
                                          input logic [7:0] b);
    c = c ^ {24'h000000, b};
    for (int k = 0; k < 8; k++)
      c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
    return c;
  endfunction : crc_upd

  // Next lane of the double-rate pins (m 0) or of the single-rate copy
  function automatic logic [8:0] lane(input int m);
    if (m != 0)
      return sdr_q.pop_front();
    return lnk_q.pop_front();
  endfunction : lane

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // One frame end to end; gap below len makes the source starve
  task automatic send(input int len, input int e, input bit er,
                      input int gap, input logic [7:0] base);
    int t0;
    int n;
    logic [31:0] c;
    @(posedge ref_clk);
    #1;
    {m_len, m_emp, m_err, m_gap, m_base} = {8'(len), 3'(e), er, 8'(gap), base};
    go = 1'b1;
    @(posedge ref_clk);
    #1;
    go = 1'b0;
    t0 = term_cnt;
    for (int i = 0; i < 3000 && term_cnt == t0; i++)
      @(posedge ref_clk);
    if (term_cnt == t0)
    begin
      failures++;
      $display("ERROR %0t: frame never terminated", $time);
    end
    n = (gap < len) ? 8*gap : 8*len - e;
    for (int m = 0; m < 2; m++)
    begin
      // Anything before the start octet must be idle, also dropped words
      while ((m ? sdr_q.size() : lnk_q.size()) > 0
             && (m ? sdr_q[0] : lnk_q[0]) !== {1'b1, XC_START})
        check(lane(m), {1'b1, XC_IDLE});
      check(lane(m), {1'b1, XC_START});
      for (int i = 0; i < 7; i++)
        check(lane(m), {1'b0, (i < 6) ? XC_PRE : XC_SFD});
      c = CRC_INIT;
      for (int i = 0; i < n; i++)
      begin
        check(lane(m), {1'b0, base + 8'(i)});
        c = crc_upd(c, base + 8'(i));
      end
      if (gap < len)
        check(lane(m), {1'b1, XC_ERR});
      else
      begin
        c = ~c;
        for (int i = 0; i < 4; i++)
          check(lane(m), {1'b0, c[8*i +: 8]});
        if (er)
          check(lane(m), {1'b1, XC_ERR});
        check(lane(m), {1'b1, XC_TERM});
      end
    end
    if (gap >= len)
      check(m_reads, len);
    check({sdr_ctrl, s_dctrl}, {CTL_ALL, 4'hf});
    check(sdr_data, {LANES{XC_IDLE}});
    lnk_q.delete();
    sdr_q.delete();
  endtask : send

  task automatic reset_state();
    repeat (12) @(posedge ref_clk);
    check(rd, 1'b0);
    check(ddr_ctrl, 4'hf);
    check(ddr_data, 32'h07070707);
    check(sdr_ctrl, CTL_ALL);
    check(sdr_data, {LANES{XC_IDLE}});
    check(s_ctrl, CTL_ALL);
    #1;
    nrst = 1'b1;
  endtask : reset_state

  task automatic clock_lag();
    @(posedge link_clk);
    #4;
    check(ddr_clk, 1'b0);
    #8;
    check(ddr_clk, 1'b1);
  endtask : clock_lag

  initial
  begin
    #300000;
    failures++;
    $display("ERROR %0t: watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    reset_state();
    clock_lag();
    repeat (4) @(posedge ref_clk);
    lnk_q.delete();
    sdr_q.delete();
    send(3, 0, 1'b0, 255, 8'h10);
    // Every empty count, frame lengths from one word up
    for (int e = 0; e < 8; e++)
      send(1 + e % 3, e, 1'b0, 255, 8'(32*e));
    send(2, 5, 1'b1, 255, 8'h40);
    send(4, 0, 1'b0, 2, 8'h80);
    send(2, 0, 1'b0, 255, 8'hc0);
    stop_test();
  end
endmodule : xtm_tx_mac_bench
